//--- logic/ectr_consts.vh
// register offsets, field positions, reset values and scale constants for the tuning bank
// assumes word-aligned apb access; offsets are register indices, byte address is index * 4
`ifndef ECTR_CONSTS_VH
`define ECTR_CONSTS_VH
`define ECTR_IDX_A_CONV 8'h09
`define ECTR_IDX_A_NOISE 8'h0a
`define ECTR_IDX_A_CTRL 8'h08
`define ECTR_IDX_B_CTRL 8'h28
`define ECTR_IDX_B_CONV 8'h29
`define ECTR_IDX_B_NOISE 8'h2a
`define ECTR_IDX_A_STAT 8'h0b
`define ECTR_IDX_B_STAT 8'h2b
`define ECTR_RST_CONV 8'h54
`define ECTR_RST_NOISE 8'h16
`define ECTR_RST_CTRL 8'h00
`define ECTR_CONV_MASK 8'h7c
`define ECTR_BIT_SEL 0
`define ECTR_BIT_DET 1
`define ECTR_BIT_CLR 2
`define ECTR_DUR_LSB 4
`define ECTR_SLOW_LSB 2
`define ECTR_FAST_UNIT 16'h0400
`endif

//--- logic/ectr_chan.v
// one canceller's tuning state: fast-convergence timer, adaptation step and noise gain
// assumes path_change is a one-cycle pulse on pclk and tick is a one-cycle enable
`include "ectr_consts.vh"
module ectr_chan #(
   parameter CNT_W = 16
) (
   input wire pclk,
   input wire presetn,
   input wire tick,
   input wire [7:0] conv,
   input wire [7:0] ctrl,
   input wire [7:0] noise_scale,
   input wire path_change,
   input wire [15:0] noise_in,
   output reg fast_mode,
   output reg estimate_clear,
   output reg [3:0] adapt_shift,
   output reg [23:0] noise_out
);
   reg [CNT_W-1:0] fast_cnt;
   wire [2:0] dur = conv[`ECTR_DUR_LSB+2:`ECTR_DUR_LSB];
   wire [1:0] slow = conv[`ECTR_SLOW_LSB+1:`ECTR_SLOW_LSB];
   wire restart = path_change & ctrl[`ECTR_BIT_DET];
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fast_cnt <= {CNT_W{1'b0}};
         fast_mode <= 1'b0;
         estimate_clear <= 1'b0;
         adapt_shift <= 4'h0;
         noise_out <= 24'h00_0000;
      end else begin
         // restart wins over expiry so a detection is never lost
         if (restart) begin
            fast_cnt <= dur * `ECTR_FAST_UNIT;
            fast_mode <= (dur != 3'h0);
         end else if (tick && fast_mode) begin
            fast_cnt <= fast_cnt - 1'b1;
            if (fast_cnt <= 1) begin
               fast_mode <= 1'b0;
            end
         end
         estimate_clear <= restart & ctrl[`ECTR_BIT_CLR];
         // step is divided by 2**slow; fast mode uses the full step
         adapt_shift <= fast_mode ? 4'h0 : {2'b00, slow};
         // unsigned product: larger scale never gives a smaller level
         noise_out <= noise_in * noise_scale;
      end
   end
endmodule // ectr_chan

//--- logic/ectr_top.v
// apb register bank for both cancellers and their tuning logic
// assumes a 50 MHz pclk from the apb fabric; path-change pulses come from pclk-domain logic
//
// How it works
// - nonzero slowdown value divides adaptation speed by two to that power, except in fast mode, which uses the full step.
// - comfort noise is scaled by the 8-bit noise scale register.
// - larger noise scale value gives a monotonically non-decreasing comfort noise level.
// - noise scale registers reset to 16 hex.
// - canceller b convergence control decodes at base plus a4 hex (register index 29 hex).
//
// Local design decision: the APB slave port.
`include "ectr_consts.vh"
module ectr_top #(
   parameter CNT_W = 16,
   parameter TICK_DIV = 16'd50
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire path_change_a,
   input wire path_change_b,
   input wire [15:0] noise_in_a,
   input wire [15:0] noise_in_b,
   output reg suppressor_variant_a,
   output reg suppressor_variant_b,
   output wire fast_mode_a,
   output wire fast_mode_b,
   output wire estimate_clear_a,
   output wire estimate_clear_b,
   output wire [3:0] adapt_shift_a,
   output wire [3:0] adapt_shift_b,
   output wire [23:0] noise_out_a,
   output wire [23:0] noise_out_b
);
   reg [7:0] conv_a;
   reg [7:0] conv_b;
   reg [7:0] noise_a;
   reg [7:0] noise_b;
   reg [7:0] ctrl_a;
   reg [7:0] ctrl_b;
   reg [15:0] div_cnt;
   reg tick;
   reg [7:0] rd_val;
   reg rd_ok;
   wire [9:0] idx = paddr[11:2];
   wire access = psel & penable;
   wire wr = access & pwrite;

   function hit;
      input [9:0] i;
      input [7:0] r;
      begin
         hit = (i == {2'b00, r});
      end
   endfunction

   // one-microsecond enable at 50 MHz for the fast-convergence timers
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_cnt <= 16'h0000;
         tick <= 1'b0;
      end else begin
         tick <= (div_cnt == TICK_DIV - 1'b1);
         div_cnt <= (div_cnt == TICK_DIV - 1'b1) ? 16'h0000 : div_cnt + 1'b1;
      end
   end

   always @* begin
      rd_ok = 1'b1;
      rd_val = 8'h00;
      if (hit(idx, `ECTR_IDX_A_CONV)) begin
         rd_val = conv_a;
      end else if (hit(idx, `ECTR_IDX_B_CONV)) begin
         rd_val = conv_b;
      end else if (hit(idx, `ECTR_IDX_A_NOISE)) begin
         rd_val = noise_a;
      end else if (hit(idx, `ECTR_IDX_B_NOISE)) begin
         rd_val = noise_b;
      end else if (hit(idx, `ECTR_IDX_A_CTRL)) begin
         rd_val = ctrl_a;
      end else if (hit(idx, `ECTR_IDX_B_CTRL)) begin
         rd_val = ctrl_b;
      end else if (hit(idx, `ECTR_IDX_A_STAT)) begin
         rd_val = {5'h00, estimate_clear_a, adapt_shift_a != 4'h0, fast_mode_a};
      end else if (hit(idx, `ECTR_IDX_B_STAT)) begin
         rd_val = {5'h00, estimate_clear_b, adapt_shift_b != 4'h0, fast_mode_b};
      end else begin
         rd_ok = 1'b0;
      end
   end

   // zero-wait slave: pready rises in the access phase, registered from the setup cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conv_a <= `ECTR_RST_CONV;
         conv_b <= `ECTR_RST_CONV;
         noise_a <= `ECTR_RST_NOISE;
         noise_b <= `ECTR_RST_NOISE;
         ctrl_a <= `ECTR_RST_CTRL;
         ctrl_b <= `ECTR_RST_CTRL;
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         suppressor_variant_a <= 1'b0;
         suppressor_variant_b <= 1'b0;
      end else begin
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & ~rd_ok;
         prdata <= (psel & ~penable & ~pwrite) ? {24'h00_0000, rd_val} : 32'h0000_0000;
         if (wr && pready && rd_ok) begin
            // must-be-zero bits are forced so the field decode stays clean
            if (hit(idx, `ECTR_IDX_A_CONV)) conv_a <= pwdata[7:0] & `ECTR_CONV_MASK;
            if (hit(idx, `ECTR_IDX_B_CONV)) conv_b <= pwdata[7:0] & `ECTR_CONV_MASK;
            if (hit(idx, `ECTR_IDX_A_NOISE)) noise_a <= pwdata[7:0];
            if (hit(idx, `ECTR_IDX_B_NOISE)) noise_b <= pwdata[7:0];
            if (hit(idx, `ECTR_IDX_A_CTRL)) ctrl_a <= pwdata[7:0] & 8'h07;
            if (hit(idx, `ECTR_IDX_B_CTRL)) ctrl_b <= pwdata[7:0] & 8'h07;
         end
         suppressor_variant_a <= ctrl_a[`ECTR_BIT_SEL];
         suppressor_variant_b <= ctrl_b[`ECTR_BIT_SEL];
      end
   end

   ectr_chan #(.CNT_W(CNT_W)) u_chan_a (
      .pclk(pclk),
      .presetn(presetn),
      .tick(tick),
      .conv(conv_a),
      .ctrl(ctrl_a),
      .noise_scale(noise_a),
      .path_change(path_change_a),
      .noise_in(noise_in_a),
      .fast_mode(fast_mode_a),
      .estimate_clear(estimate_clear_a),
      .adapt_shift(adapt_shift_a),
      .noise_out(noise_out_a)
   );

   ectr_chan #(.CNT_W(CNT_W)) u_chan_b (
      .pclk(pclk),
      .presetn(presetn),
      .tick(tick),
      .conv(conv_b),
      .ctrl(ctrl_b),
      .noise_scale(noise_b),
      .path_change(path_change_b),
      .noise_in(noise_in_b),
      .fast_mode(fast_mode_b),
      .estimate_clear(estimate_clear_b),
      .adapt_shift(adapt_shift_b),
      .noise_out(noise_out_b)
   );
endmodule // ectr_top

//--- tb/ectr_props.sv
// apb handshake and canceller a output checks for the tuning bank
// assumes one pclk domain and presetn asynchronous, active low
module ectr_props (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire suppressor_variant_a,
   input wire fast_mode_a,
   input wire estimate_clear_a,
   input wire [3:0] adapt_shift_a
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire wr_ctrl = psel && penable && pready && pwrite && paddr[11:2] == 10'h008;
   a_ready_setup: assert property (psel && !penable |=> pready) else $error("no ready");
   a_ready_access: assert property (pready |-> psel && penable) else $error("stray ready");
   a_err_ready: assert property (pslverr |-> pready) else $error("stray error");
   a_rdata_upper: assert property (pready |-> prdata[31:8] == 0) else $error("upper bits set");
   a_unmapped_err: assert property (psel && !penable && paddr[11:2] == 10'h3ff |=> pslverr)
      else $error("no error on unmapped");
   a_variant_follow: assert property (
      wr_ctrl |-> ##2 suppressor_variant_a == $past(pwdata[0], 2)) else $error("bad variant");
   a_fast_shift: assert property (
      fast_mode_a |=> adapt_shift_a == 4'h0) else $error("slow step in fast mode");
   a_clear_pulse: assert property (
      estimate_clear_a |=> !estimate_clear_a) else $error("clear too long");
   cover property (wr_ctrl);
   cover property (estimate_clear_a);
   cover property (pslverr);
endmodule // ectr_props
bind ectr_top ectr_props i_props (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .suppressor_variant_a(suppressor_variant_a),
   .fast_mode_a(fast_mode_a), .estimate_clear_a(estimate_clear_a),
   .adapt_shift_a(adapt_shift_a));

//--- tb/echo_canceller_tuning_regs_bench.sv
// register and tuning tests for the tuning bank through its apb port
// assumes ectr_top with a shortened tick so fast convergence ends quickly
module echo_canceller_tuning_regs_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, path_change_a = 0;
   logic path_change_b = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic [15:0] noise_in_a = 16'h0100, noise_in_b = 16'h0100;
   logic pready, pslverr, err, sva, svb, fma, fmb, clr_a, clr_b;
   logic [3:0] asa, asb;
   logic [23:0] noa, nob;
   int n_mismatch = 0, checks_done = 0, cyc = 0;
   ectr_top #(.TICK_DIV(16'd2)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .path_change_a(path_change_a),
      .path_change_b(path_change_b), .noise_in_a(noise_in_a), .noise_in_b(noise_in_b),
      .suppressor_variant_a(sva), .suppressor_variant_b(svb), .fast_mode_a(fma),
      .fast_mode_b(fmb), .estimate_clear_a(clr_a), .estimate_clear_b(clr_b),
      .adapt_shift_a(asa), .adapt_shift_b(asb), .noise_out_a(noa), .noise_out_b(nob));
   initial forever #10 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 40000) begin
         n_mismatch++;
         end_of_test();
      end
   end
   task end_of_test;
      if (n_mismatch == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // request held until pready is sampled high; data taken at that edge
   task xfer(input logic w, input logic [9:0] i, input logic [31:0] d);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, i, 2'b00, d};
      @(posedge pclk);
      penable <= 1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      {rd, err} = {prdata, pslverr};
      {psel, penable} <= 2'b00;
   endtask
   task rdchk(input string what, input logic [9:0] i, input logic [31:0] exp);
      xfer(0, i, 0);
      chk(what, rd, exp);
   endtask
   task fast_off;
      for (int k = 0; k < 12000 && fma !== 1'b0; k++) @(posedge pclk);
      chk("fast off", fma, 0);
   endtask
   // adapt_shift follows fast_mode one cycle later, so the step is checked at the second edge
   task pulse(input logic b, input logic clr);
      @(posedge pclk);
      {path_change_b, path_change_a} <= b ? 2'b10 : 2'b01;
      @(posedge pclk);
      {path_change_b, path_change_a} <= 2'b00;
      #1 chk("fast on", b ? fmb : fma, 1);
      chk("clear", b ? clr_b : clr_a, clr);
      @(posedge pclk);
      #1 chk("clear end", b ? clr_b : clr_a, 0);
      chk("fast step", b ? asb : asa, 0);
   endtask
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1;
      rdchk("a conv", 10'h009, 32'h0000_0054);
      rdchk("b conv", 10'h029, 32'h0000_0054);
      rdchk("a noise", 10'h00a, 32'h0000_0016);
      rdchk("b noise", 10'h02a, 32'h0000_0016);
      xfer(1, 10'h029, 32'h0000_00ff);
      rdchk("b conv", 10'h029, 32'h0000_007c);
      rdchk("a conv", 10'h009, 32'h0000_0054);
      xfer(0, 10'h3ff, 0);
      chk("unmapped err", err, 1);
      for (int v = 0; v < 4; v++) begin
         xfer(1, 10'h008, v & 1);
         xfer(1, 10'h028, v >> 1);
         repeat (2) @(posedge pclk);
         chk("variant", {sva, svb}, {v[0], v[1]});
      end
      chk("noise", noa, 24'h00_1600);
      chk("b noise out", nob, 24'h00_1600);
      xfer(1, 10'h00a, 32'h0000_0074);
      repeat (2) @(posedge pclk);
      chk("noise", noa, 24'h00_7400);
      fast_off();
      // detect bit is low here, so a path change must leave both outputs quiet
      @(posedge pclk);
      path_change_a <= 1;
      @(posedge pclk);
      path_change_a <= 0;
      #1 chk("ignored", {fma, clr_a}, 0);
      for (int s = 1; s < 4; s++) begin
         xfer(1, 10'h009, 32'h10 | s << 2);
         repeat (2) @(posedge pclk);
         chk("slow step", asa, s);
      end
      xfer(1, 10'h008, 32'h0000_0006);
      pulse(0, 1);
      fast_off();
      xfer(1, 10'h008, 32'h0000_0002);
      pulse(0, 0);
      rdchk("a status", 10'h00b, 32'h0000_0001);
      xfer(1, 10'h028, 32'h0000_0006);
      pulse(1, 1);
      rdchk("b status", 10'h02b, 32'h0000_0001);
      end_of_test();
   end
endmodule // echo_canceller_tuning_regs_bench
